//--- rtl/ctr_pkg.sv
// Constants for the CAN timestamp, timeout, retry and clock-stop control block.
// Assumes a protocol core on the same clock that gives sample-point ticks and frame events.
`default_nettype none
package ctr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STAMP_W = 16;
  localparam int TCP_W = 4;
  // Register offsets
  localparam logic [7:0] OFS_CORE_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAMP_CFG = 8'h04;
  localparam logic [7:0] OFS_STAMP_CNT = 8'h08;
  localparam logic [7:0] OFS_TO_CFG = 8'h0C;
  localparam logic [7:0] OFS_TO_VAL = 8'h10;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_TX_PEND = 8'h1C;
  localparam logic [7:0] OFS_TX_CANCEL = 8'h20;
  localparam logic [7:0] OFS_TX_OCC = 8'h24;
  localparam logic [7:0] OFS_TX_CDONE = 8'h28;
  // Core control fields
  localparam int CC_INIT = 0;
  localparam int CC_CSR = 1;
  localparam int CC_NRM = 2;
  localparam int CC_MON = 3;
  localparam int CC_TXEV = 4;
  localparam int CC_CSA = 5;
  // Stamp config fields
  localparam int SC_TCP_LSB = 0;
  localparam int SC_TSS = 4;
  // Timeout config fields
  localparam int TC_EN = 0;
  localparam int TC_TOS_LSB = 1;
  localparam int TC_TOP_LSB = 16;
  // Interrupt flag fields
  localparam int IF_WRAP = 0;
  localparam int IF_TOUT = 1;
  // Reset values and counter compare values
  localparam logic RST_INIT = 1'b1;
  localparam logic RST_NRM = 1'b0;
  localparam logic [15:0] RST_TOP = 16'hFFFF;
  localparam logic [15:0] STAMP_MAX = 16'hFFFF;
  localparam logic [15:0] TOC_ONE = 16'h0001;
  localparam logic [15:0] TOC_ZERO = 16'h0000;
  // Timeout modes
  localparam logic [1:0] TOS_CONT = 2'h0;
  localparam logic [1:0] TOS_FIFO0 = 2'h1;
  localparam logic [1:0] TOS_FIFO1 = 2'h2;
  localparam logic [1:0] TOS_TXEV = 2'h3;
  // Tx event type codes
  localparam logic [1:0] ET_TX = 2'h1;
  localparam logic [1:0] ET_SPITE = 2'h2;
  typedef enum logic [1:0] {
    CS_RUN = 2'b00,
    CS_WAIT_TX = 2'b01,
    CS_WAIT_IDLE = 2'b10,
    CS_ACK = 2'b11
  } ctr_cs_e;
endpackage
`default_nettype wire

//--- rtl/ctr_top.sv
// CAN timestamp, timeout, no-retry and clock-stop control with register port.
// Assumes protocol-core inputs on core_clk_in; only the CAN receive pin and resetn_in are asynchronous.
//
// Design decisions made here: the register offsets and the plain strobed port.
`default_nettype none
module ctr_top #(
  parameter int NBUF = 8,
  parameter int IW = 3
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic sample_point_in,
  input wire logic bus_idle_in,
  input wire logic bus_off_in,
  input wire logic sof_in,
  input wire logic [15:0] ext_stamp_in,
  input wire logic fifo0_nonempty_in,
  input wire logic fifo1_nonempty_in,
  input wire logic txev_nonempty_in,
  input wire logic tx_start_in,
  input wire logic tx_success_in,
  input wire logic tx_fail_in,
  input wire logic [IW-1:0] tx_index_in,
  input wire logic can_rx_pin_in,
  input wire logic core_tx_in,
  output logic can_tx_pin_out,
  output logic core_rx_out,
  output logic [15:0] frame_stamp_out,
  output logic [NBUF-1:0] tx_pending_out,
  output logic tx_allowed_out,
  output logic config_hold_out,
  output logic clock_stop_ack_out,
  output logic txev_write_out,
  output logic [1:0] txev_type_out,
  output logic [15:0] txev_stamp_out,
  output logic [IW-1:0] txev_index_out,
  output logic irq_out
);

  // ==========================================
  // State
  typedef struct packed {
    logic [1:0] rx_sync;
    logic core_rx;
    logic can_tx;
    logic init;
    logic clock_stop_request;
    logic no_retry;
    logic monitor;
    logic txev_en;
    logic clock_stop_ack;
    ctr_pkg::ctr_cs_e cs;
    logic [3:0] tick_prescaler;
    logic timestamp_source_select;
    logic [3:0] ps;
    logic [15:0] stamp;
    logic [15:0] frame_stamp;
    logic to_en;
    logic [1:0] timeout_mode_select;
    logic [15:0] top;
    logic [15:0] timeout_count_value;
    logic [1:0] flags;
    logic [1:0] irq_en;
    logic irq;
    logic [NBUF-1:0] pend;
    logic [NBUF-1:0] cancel;
    logic [NBUF-1:0] started;
    logic [NBUF-1:0] occ;
    logic [NBUF-1:0] cdone;
    logic allowed;
    logic txev_wr;
    logic [1:0] txev_type;
    logic [15:0] txev_stamp;
    logic [IW-1:0] txev_idx;
    logic [31:0] rdata;
  } ctr_state_s;

  ctr_state_s q;
  ctr_state_s n;
  logic [1:0] rst_sync_q;
  logic rst_n;

  // ==========================================
  // Reset release
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================
  // Next state
  logic tick;
  logic wr_cc;
  logic wr_sc;
  logic wr_cnt;
  logic wr_tc;
  logic wr_tv;
  logic fifo_ne;
  logic [15:0] stamp_now;
  logic [NBUF-1:0] bit_i;
  logic [NBUF-1:0] early;

  always_comb
  begin
    n = q;
    n.txev_wr = 1'b0;
    bit_i = '0;
    bit_i[tx_index_in] = 1'b1;
    wr_cc = reg_wr_in && reg_addr_in == ctr_pkg::OFS_CORE_CTRL;
    wr_sc = reg_wr_in && reg_addr_in == ctr_pkg::OFS_STAMP_CFG;
    wr_cnt = reg_wr_in && reg_addr_in == ctr_pkg::OFS_STAMP_CNT;
    wr_tc = reg_wr_in && reg_addr_in == ctr_pkg::OFS_TO_CFG;
    wr_tv = reg_wr_in && reg_addr_in == ctr_pkg::OFS_TO_VAL;

    // Pin sampling
    n.rx_sync = {q.rx_sync[0], can_rx_pin_in};
    n.core_rx = q.rx_sync[1];
    n.can_tx = q.monitor ? 1'b1 : core_tx_in;

    // Software writes first, hardware sets after them
    if (wr_cc)
    begin
      n.init = reg_wdata_in[ctr_pkg::CC_INIT];
      n.clock_stop_request = reg_wdata_in[ctr_pkg::CC_CSR];
      n.no_retry = reg_wdata_in[ctr_pkg::CC_NRM];
      n.monitor = reg_wdata_in[ctr_pkg::CC_MON];
      n.txev_en = reg_wdata_in[ctr_pkg::CC_TXEV];
    end
    if (wr_sc)
    begin
      n.tick_prescaler = reg_wdata_in[ctr_pkg::SC_TCP_LSB +: ctr_pkg::TCP_W];
      n.timestamp_source_select = reg_wdata_in[ctr_pkg::SC_TSS];
    end
    if (wr_tc)
    begin
      n.to_en = reg_wdata_in[ctr_pkg::TC_EN];
      n.timeout_mode_select = reg_wdata_in[ctr_pkg::TC_TOS_LSB +: 2];
      n.top = reg_wdata_in[ctr_pkg::TC_TOP_LSB +: ctr_pkg::STAMP_W];
    end
    if (reg_wr_in && reg_addr_in == ctr_pkg::OFS_IRQ_EN)
      n.irq_en = reg_wdata_in[1:0];
    if (reg_wr_in && reg_addr_in == ctr_pkg::OFS_IRQ_FLAG)
      n.flags = q.flags & ~reg_wdata_in[1:0];
    if (reg_wr_in && reg_addr_in == ctr_pkg::OFS_TX_PEND)
    begin
      n.pend = q.pend | reg_wdata_in[NBUF-1:0];
      n.occ = q.occ & ~reg_wdata_in[NBUF-1:0];
      n.cdone = q.cdone & ~reg_wdata_in[NBUF-1:0];
    end
    if (reg_wr_in && reg_addr_in == ctr_pkg::OFS_TX_CANCEL)
      n.cancel = q.cancel | (reg_wdata_in[NBUF-1:0] & q.pend);

    // Prescaler and stamp counter
    tick = sample_point_in && q.ps == q.tick_prescaler;
    if (sample_point_in)
      n.ps = tick ? 4'h0 : q.ps + 4'h1;
    if (wr_cnt)
      n.stamp = 16'h0000;
    else if (tick && !q.timestamp_source_select)
    begin
      n.stamp = q.stamp + 16'h0001;
      if (q.stamp == ctr_pkg::STAMP_MAX)
        n.flags[ctr_pkg::IF_WRAP] = 1'b1;
    end
    stamp_now = q.timestamp_source_select ? ext_stamp_in : q.stamp;
    if (sof_in)
      n.frame_stamp = stamp_now;

    // Timeout counter
    case (q.timeout_mode_select)
      ctr_pkg::TOS_FIFO0: fifo_ne = fifo0_nonempty_in;
      ctr_pkg::TOS_FIFO1: fifo_ne = fifo1_nonempty_in;
      ctr_pkg::TOS_TXEV: fifo_ne = txev_nonempty_in;
      default: fifo_ne = 1'b0;
    endcase
    if (q.timeout_mode_select == ctr_pkg::TOS_CONT)
    begin
      if (q.init || !q.to_en)
        n.timeout_count_value = q.top;
      else if (wr_tv)
        n.timeout_count_value = q.top;
      else if (tick)
      begin
        if (q.timeout_count_value <= ctr_pkg::TOC_ONE)
        begin
          n.timeout_count_value = q.top;
          n.flags[ctr_pkg::IF_TOUT] = 1'b1;
        end
        else
          n.timeout_count_value = q.timeout_count_value - 16'h0001;
      end
    end
    else if (!fifo_ne)
      n.timeout_count_value = q.top;
    else if (tick && !q.init && q.to_en && q.timeout_count_value != ctr_pkg::TOC_ZERO)
    begin
      n.timeout_count_value = q.timeout_count_value - 16'h0001;
      if (q.timeout_count_value == ctr_pkg::TOC_ONE)
        n.flags[ctr_pkg::IF_TOUT] = 1'b1;
    end

    // Transmission outcomes
    if (tx_start_in)
      n.started = n.started | bit_i;
    if (tx_success_in)
    begin
      n.pend = n.pend & ~bit_i;
      n.started = n.started & ~bit_i;
      n.occ = n.occ | bit_i;
      if (|(q.cancel & bit_i))
        n.cdone = n.cdone | bit_i;
      n.cancel = n.cancel & ~bit_i;
      if (q.txev_en)
      begin
        n.txev_wr = 1'b1;
        n.txev_type = (q.no_retry || |(q.cancel & bit_i)) ? ctr_pkg::ET_SPITE : ctr_pkg::ET_TX;
        n.txev_stamp = q.frame_stamp;
        n.txev_idx = tx_index_in;
      end
    end
    if (tx_fail_in)
    begin
      n.started = n.started & ~bit_i;
      if (q.no_retry || |(q.cancel & bit_i))
      begin
        n.pend = n.pend & ~bit_i;
        n.cdone = n.cdone | bit_i;
        n.cancel = n.cancel & ~bit_i;
      end
      // Otherwise the request stays pending and is retried
    end
    early = q.cancel & q.pend & ~q.started & ~(tx_start_in ? bit_i : '0);
    n.pend = n.pend & ~early;
    n.cancel = n.cancel & ~early;
    n.cdone = n.cdone | early;

    // Clock stop handshake
    case (q.cs)
      ctr_pkg::CS_RUN:
      begin
        if (n.clock_stop_request)
          n.cs = ctr_pkg::CS_WAIT_TX;
      end
      ctr_pkg::CS_WAIT_TX:
      begin
        if (!n.clock_stop_request)
          n.cs = ctr_pkg::CS_RUN;
        else if (q.pend == '0)
          n.cs = ctr_pkg::CS_WAIT_IDLE;
      end
      ctr_pkg::CS_WAIT_IDLE:
      begin
        if (!n.clock_stop_request)
          n.cs = ctr_pkg::CS_RUN;
        else if (bus_idle_in)
        begin
          n.init = 1'b1;
          n.clock_stop_ack = 1'b1;
          n.cs = ctr_pkg::CS_ACK;
        end
      end
      ctr_pkg::CS_ACK:
      begin
        if (!n.clock_stop_request)
        begin
          n.clock_stop_ack = 1'b0;
          n.cs = ctr_pkg::CS_RUN;
        end
      end
      default: n.cs = ctr_pkg::CS_RUN;
    endcase
    if (bus_off_in)
      n.init = 1'b1;
    n.allowed = !n.init;
    n.irq = |(n.flags & n.irq_en);

    // Read port stays live in every clock-stop state
    n.rdata = 32'h0000_0000;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        ctr_pkg::OFS_CORE_CTRL:
        begin
          n.rdata[ctr_pkg::CC_INIT] = q.init;
          n.rdata[ctr_pkg::CC_CSR] = q.clock_stop_request;
          n.rdata[ctr_pkg::CC_NRM] = q.no_retry;
          n.rdata[ctr_pkg::CC_MON] = q.monitor;
          n.rdata[ctr_pkg::CC_TXEV] = q.txev_en;
          n.rdata[ctr_pkg::CC_CSA] = q.clock_stop_ack;
        end
        ctr_pkg::OFS_STAMP_CFG:
        begin
          n.rdata[ctr_pkg::SC_TCP_LSB +: ctr_pkg::TCP_W] = q.tick_prescaler;
          n.rdata[ctr_pkg::SC_TSS] = q.timestamp_source_select;
        end
        ctr_pkg::OFS_STAMP_CNT: n.rdata[15:0] = stamp_now;
        ctr_pkg::OFS_TO_CFG:
        begin
          n.rdata[ctr_pkg::TC_EN] = q.to_en;
          n.rdata[ctr_pkg::TC_TOS_LSB +: 2] = q.timeout_mode_select;
          n.rdata[ctr_pkg::TC_TOP_LSB +: ctr_pkg::STAMP_W] = q.top;
        end
        ctr_pkg::OFS_TO_VAL: n.rdata[15:0] = q.timeout_count_value;
        ctr_pkg::OFS_IRQ_FLAG: n.rdata[1:0] = q.flags;
        ctr_pkg::OFS_IRQ_EN: n.rdata[1:0] = q.irq_en;
        ctr_pkg::OFS_TX_PEND: n.rdata[NBUF-1:0] = q.pend;
        ctr_pkg::OFS_TX_CANCEL: n.rdata[NBUF-1:0] = q.cancel;
        ctr_pkg::OFS_TX_OCC: n.rdata[NBUF-1:0] = q.occ;
        ctr_pkg::OFS_TX_CDONE: n.rdata[NBUF-1:0] = q.cdone;
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.rx_sync <= 2'h3;
      q.core_rx <= 1'b1;
      q.can_tx <= 1'b1;
      q.init <= ctr_pkg::RST_INIT;
      q.no_retry <= ctr_pkg::RST_NRM;
      q.cs <= ctr_pkg::CS_RUN;
      q.top <= ctr_pkg::RST_TOP;
      q.timeout_count_value <= ctr_pkg::RST_TOP;
      q.txev_type <= ctr_pkg::ET_TX;
    end
    else if (ce_in)
      q <= n;
  end

  // ==========================================
  // Outputs
  assign reg_rdata_out = q.rdata;
  assign can_tx_pin_out = q.can_tx;
  assign core_rx_out = q.core_rx;
  assign frame_stamp_out = q.frame_stamp;
  assign tx_pending_out = q.pend;
  assign tx_allowed_out = q.allowed;
  assign config_hold_out = q.init;
  assign clock_stop_ack_out = q.clock_stop_ack;
  assign txev_write_out = q.txev_wr;
  assign txev_type_out = q.txev_type;
  assign txev_stamp_out = q.txev_stamp;
  assign txev_index_out = q.txev_idx;
  assign irq_out = q.irq;

endmodule
`default_nettype wire

//--- verif/ctr_bus_model.sv
// Far side of the CAN pins: one other node and bit timing.
// Assumes the bench sets node_level and calls tick.
`default_nettype none
module ctr_bus_model (
  input wire logic clk_in,
  input wire logic tx_pin_in,
  output logic rx_pin_out,
  output logic sample_point_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic node_level = 1'b1;
  // Wired-and bus, dominant wins
  assign rx_pin_out = tx_pin_in & node_level;
  initial sample_point_out = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in) sample_point_out <= 1'b1;
    @(posedge clk_in) sample_point_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verif/ctr_chk_properties.sv
// Port checker for ctr_top.
// Assumes bind into ctr_top; sees its ports only.
`default_nettype none
module ctr_chk #(
  parameter int NBUF = 8,
  parameter int IW = 3
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic bus_idle_in,
  input wire logic bus_off_in,
  input wire logic tx_success_in,
  input wire logic [IW-1:0] tx_index_in,
  input wire logic can_rx_pin_in,
  input wire logic core_tx_in,
  input wire logic can_tx_pin_out,
  input wire logic core_rx_out,
  input wire logic [NBUF-1:0] tx_pending_out,
  input wire logic tx_allowed_out,
  input wire logic config_hold_out,
  input wire logic clock_stop_ack_out,
  input wire logic txev_write_out,
  input wire logic [IW-1:0] txev_index_out
);
  logic [2:0] warm_q;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in || warm_q != 3'h7);
  // ====================
  // Warm-up after reset release, covers the internal reset delay and pin pipeline
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      warm_q <= 3'h0;
    else if (warm_q != 3'h7)
      warm_q <= warm_q + 3'h1;
  end
  // ====================
  // Properties
  property p_rdata;
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  property p_allow;
    tx_allowed_out == !config_hold_out;
  endproperty
  a_allow: assert property (p_allow) else $error("tx allowed during hold");
  property p_ack;
    $rose(clock_stop_ack_out) |-> config_hold_out && tx_pending_out == '0 && $past(bus_idle_in);
  endproperty
  a_ack: assert property (p_ack) else $error("early stop ack");
  property p_succ;
    tx_success_in |=> !tx_pending_out[$past(tx_index_in)];
  endproperty
  a_succ: assert property (p_succ) else $error("pending kept after success");
  property p_boff;
    bus_off_in |=> config_hold_out;
  endproperty
  a_boff: assert property (p_boff) else $error("no hold on bus off");
  property p_txev;
    txev_write_out |-> $past(tx_success_in) && txev_index_out == $past(tx_index_in) ##1 !txev_write_out;
  endproperty
  a_txev: assert property (p_txev) else $error("bad event write");
  property p_rx;
    core_rx_out == $past(can_rx_pin_in, 3);
  endproperty
  a_rx: assert property (p_rx) else $error("rx path broken");
  property p_tx;
    $past(core_tx_in) |-> can_tx_pin_out;
  endproperty
  a_tx: assert property (p_tx) else $error("dominant without cause");
endmodule
bind ctr_top ctr_chk #(.NBUF(NBUF), .IW(IW)) u_chk (.core_clk_in, .resetn_in, .reg_rd_in, .reg_rdata_out,
  .bus_idle_in, .bus_off_in, .tx_success_in, .tx_index_in, .can_rx_pin_in, .core_tx_in, .can_tx_pin_out,
  .core_rx_out, .tx_pending_out, .tx_allowed_out, .config_hold_out, .clock_stop_ack_out, .txev_write_out,
  .txev_index_out);
`default_nettype wire

//--- verif/tb.sv
// Bench for ctr_top: registers, counters, tx outcomes, clock stop.
// Assumes ctr_bus_model on the pins and ctr_chk bound.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0, resetn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic bus_idle_in = 1'b1, bus_off_in = 1'b0, sof_in = 1'b0, fifo0_nonempty_in = 1'b0;
  logic tx_start_in = 1'b0, tx_success_in = 1'b0, tx_fail_in = 1'b0, core_tx_in = 1'b1;
  logic ce_in = 1'b1, fifo1_nonempty_in = 1'b0, txev_nonempty_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, tx_pending_out;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
  logic [15:0] ext_stamp_in = 16'h0, frame_stamp_out, txev_stamp_out;
  logic [2:0] tx_index_in = 3'h0, txev_index_out;
  logic [1:0] txev_type_out;
  logic sample_point_in, can_rx_pin_in, can_tx_pin_out, core_rx_out, tx_allowed_out;
  logic config_hold_out, clock_stop_ack_out, txev_write_out, irq_out;
  int n_errors = 0, comparisons = 0, cyc = 0;
  always #50 core_clk_in = ~core_clk_in;
  ctr_top DUT (.core_clk_in, .resetn_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .sample_point_in, .bus_idle_in, .bus_off_in, .sof_in, .ext_stamp_in, .fifo0_nonempty_in,
    .fifo1_nonempty_in, .txev_nonempty_in, .tx_start_in, .tx_success_in, .tx_fail_in, .tx_index_in,
    .can_rx_pin_in, .core_tx_in, .can_tx_pin_out, .core_rx_out, .frame_stamp_out, .tx_pending_out,
    .tx_allowed_out, .config_hold_out, .clock_stop_ack_out, .txev_write_out, .txev_type_out, .txev_stamp_out,
    .txev_index_out, .irq_out);
  ctr_bus_model bus (.clk_in(core_clk_in), .tx_pin_in(can_tx_pin_out), .rx_pin_out(can_rx_pin_in),
    .sample_point_out(sample_point_in));
  // ====================
  // Tasks
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata_out);
  endtask
  task automatic tx(input int k, input logic [2:0] i);
    @(posedge core_clk_in);
    tx_index_in <= i;
    tx_start_in <= (k == 0);
    tx_success_in <= (k == 1);
    tx_fail_in <= (k == 2);
    @(posedge core_clk_in);
    {tx_start_in, tx_success_in, tx_fail_in} <= 3'h0;
    #1;
  endtask
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_errors++;
      stop_test();
    end
  end
  // ====================
  // Sequence
  initial
  begin
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    rc(8'h00, 32'h1);
    rc(8'h0C, 32'hFFFF0000);
    rc(8'h10, 32'hFFFF);
    rc(8'h40, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h1);
    wr(8'h08, 32'hDEAD);
    rc(8'h08, 32'h0);
    bus.tick(6);
    rc(8'h08, 32'h3);
    @(posedge core_clk_in);
    ce_in <= 1'b0;
    bus.tick(4);
    ce_in <= 1'b1;
    rc(8'h08, 32'h3);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    bus.tick(65535);
    rc(8'h08, 32'hFFFF);
    rc(8'h14, 32'h0);
    bus.tick(1);
    rc(8'h08, 32'h0);
    rc(8'h14, 32'h1);
    chk("irq", 32'h0, 32'(irq_out));
    wr(8'h18, 32'h1);
    @(posedge core_clk_in);
    #1 chk("irq", 32'h1, 32'(irq_out));
    rc(8'h14, 32'h1);
    wr(8'h14, 32'h1);
    rc(8'h14, 32'h0);
    chk("irq", 32'h0, 32'(irq_out));
    wr(8'h0C, 32'h00050000);
    wr(8'h0C, 32'h00050001);
    rc(8'h10, 32'h5);
    bus.tick(2);
    rc(8'h10, 32'h3);
    wr(8'h10, 32'h0);
    rc(8'h10, 32'h5);
    bus.tick(5);
    rc(8'h10, 32'h5);
    rc(8'h14, 32'h2);
    wr(8'h14, 32'h2);
    wr(8'h0C, 32'h00050002);
    wr(8'h0C, 32'h00050003);
    bus.tick(3);
    wr(8'h10, 32'h0);
    rc(8'h10, 32'h5);
    fifo0_nonempty_in <= 1'b1;
    bus.tick(5);
    rc(8'h10, 32'h0);
    rc(8'h14, 32'h2);
    wr(8'h0C, 32'h00050005);
    rc(8'h10, 32'h5);
    fifo1_nonempty_in <= 1'b1;
    bus.tick(2);
    rc(8'h10, 32'h3);
    wr(8'h0C, 32'h00050007);
    rc(8'h10, 32'h5);
    txev_nonempty_in <= 1'b1;
    bus.tick(4);
    rc(8'h10, 32'h1);
    wr(8'h00, 32'h14);
    wr(8'h1C, 32'h04);
    chk("pend", 32'h04, 32'(tx_pending_out));
    tx(0, 3'h2);
    tx(1, 3'h2);
    chk("pend", 32'h0, 32'(tx_pending_out));
    chk("evt", 32'(ctr_pkg::ET_SPITE), 32'(txev_type_out));
    wr(8'h1C, 32'h02);
    tx(0, 3'h1);
    tx(2, 3'h1);
    chk("pend", 32'h0, 32'(tx_pending_out));
    wr(8'h00, 32'h10);
    wr(8'h1C, 32'h08);
    tx(0, 3'h3);
    tx(2, 3'h3);
    chk("pend", 32'h08, 32'(tx_pending_out));
    tx(0, 3'h3);
    tx(1, 3'h3);
    chk("evt", 32'(ctr_pkg::ET_TX), 32'(txev_type_out));
    wr(8'h00, 32'h14);
    wr(8'h1C, 32'h10);
    tx(0, 3'h4);
    wr(8'h20, 32'h10);
    tx(1, 3'h4);
    rc(8'h24, 32'h1C);
    rc(8'h28, 32'h12);
    wr(8'h1C, 32'h40);
    wr(8'h20, 32'h40);
    rc(8'h1C, 32'h0);
    rc(8'h28, 32'h52);
    wr(8'h00, 32'h08);
    core_tx_in <= 1'b0;
    bus.node_level <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    #1 chk("txpin", 32'h1, 32'(can_tx_pin_out));
    chk("rx", 32'h0, 32'(core_rx_out));
    wr(8'h00, 32'h0);
    @(posedge core_clk_in);
    #1 chk("txpin", 32'h0, 32'(can_tx_pin_out));
    core_tx_in <= 1'b1;
    bus.node_level <= 1'b1;
    ext_stamp_in <= 16'hA5C3;
    wr(8'h04, 32'h10);
    rc(8'h08, 32'hA5C3);
    @(posedge core_clk_in);
    sof_in <= 1'b1;
    @(posedge core_clk_in);
    sof_in <= 1'b0;
    #1 chk("stamp", 32'hA5C3, 32'(frame_stamp_out));
    wr(8'h00, 32'h10);
    wr(8'h1C, 32'h20);
    tx(1, 3'h5);
    chk("evwr", 32'h1, 32'(txev_write_out));
    chk("evstamp", 32'hA5C3, 32'(txev_stamp_out));
    chk("evidx", 32'h5, 32'(txev_index_out));
    chk("evt", 32'(ctr_pkg::ET_TX), 32'(txev_type_out));
    @(posedge core_clk_in);
    #1 chk("evwr", 32'h0, 32'(txev_write_out));
    bus_off_in <= 1'b1;
    @(posedge core_clk_in);
    bus_off_in <= 1'b0;
    #1 chk("hold", 32'h1, 32'(config_hold_out));
    chk("allow", 32'h0, 32'(tx_allowed_out));
    wr(8'h00, 32'h0);
    wr(8'h1C, 32'h01);
    wr(8'h00, 32'h2);
    repeat (4) @(posedge core_clk_in);
    #1 chk("ack", 32'h0, 32'(clock_stop_ack_out));
    bus_idle_in <= 1'b0;
    tx(0, 3'h0);
    tx(1, 3'h0);
    repeat (4) @(posedge core_clk_in);
    #1 chk("ack", 32'h0, 32'(clock_stop_ack_out));
    bus_idle_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    #1 chk("ack", 32'h1, 32'(clock_stop_ack_out));
    rc(8'h00, 32'h23);
    stop_test();
  end
endmodule
`default_nettype wire
